// ==== include/ela_cfg.svh ====
`ifndef ELA_CFG_SVH
`define ELA_CFG_SVH
// register byte offsets
`define ELA_CTRL_OFS 12'h000
`define ELA_LIVE_OFS 12'h004
`define ELA_STAT_OFS 12'h008
`define ELA_MASK_OFS 12'h00c
// control field positions
`define ELA_CTRL_MODE_LSB 0
`define ELA_CTRL_LOOP_BIT 2
// reset values
`define ELA_CTRL_RST 32'h0000_0000
`define ELA_MASK_RST 7'h00
// synchroniser idle: line healthy, upstream still unknown (missing)
`define ELA_SYNC_RST 10'h027
// alarm bit positions
`define ELA_B_LOS 0
`define ELA_B_LOF 1
`define ELA_B_AIS 2
`define ELA_B_RAI 3
`define ELA_B_SSL 4
`define ELA_B_RMA 5
`define ELA_B_SSA 6
// timing: activity flash half period
`define ELA_CLK_HZ 50000000
`define ELA_FLASH_MS 250
`define ELA_FLASH_CYC (`ELA_CLK_HZ / 1000 * `ELA_FLASH_MS)
`endif

// ==== include/ela_pkg.sv ====
package ela_pkg;
  // line mode: framing and signalling
  typedef enum logic [1:0] {
    ELA_E1_UNFRAMED = 2'h0,
    ELA_E1_PCM31 = 2'h1,
    ELA_E1_PCM30 = 2'h3,
    ELA_T1_FRAMED = 2'h2
  } ela_mode_t;
  typedef logic [6:0] ela_alarm_t;
endpackage : ela_pkg

// ==== verilog/ela_line_alarm.sv ====
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ela_cfg.svh"
module ela_line_alarm
  import ela_pkg::*;
#(
  parameter int FLASH_CYC = `ELA_FLASH_CYC
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // raw detector inputs from the line receiver (asynchronous)
  input wire logic LINE_CODE_OK_I,
  input wire logic LINE_FREQ_OK_I,
  input wire logic FAW_FOUND_I,
  input wire logic AIS_SEEN_I,
  input wire logic REMOTE_BIT_I,
  input wire logic TS16_VALID_I,
  input wire logic TS16_MF_BIT6_I,
  input wire logic TS16_AIS_SEEN_I,
  // upstream traffic status from the radio side (asynchronous)
  input wire logic UP_TRAFFIC_OK_I,
  input wire logic UP_TS16_OK_I,
  // outputs
  output logic TX_AIS_O,
  output logic TX_TS16_AIS_O,
  output logic ALARM_LED_O,
  output logic ACT_LED_O,
  output logic [6:0] ALARM_O,
  output logic IRQ_O
);

  // a half period under two cycles cannot be counted by the flash timer
  if (FLASH_CYC < 2) begin : g_bad_flash
    $error("FLASH_CYC must be at least 2");
  end

  localparam int NSYNC = 10;
  localparam int CW = $clog2(FLASH_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers on all line and radio inputs
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  assign raw_w = {UP_TS16_OK_I, UP_TRAFFIC_OK_I, TS16_AIS_SEEN_I, TS16_MF_BIT6_I, TS16_VALID_I,
                  REMOTE_BIT_I, AIS_SEEN_I, FAW_FOUND_I, LINE_FREQ_OK_I, LINE_CODE_OK_I};

  // reset to the idle pin levels so release raises no false alarm or status
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      meta_q <= `ELA_SYNC_RST;
      sync_q <= `ELA_SYNC_RST;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode helpers
  // full-address compare: aliases of the offsets stay unmapped
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_w;
  logic rd_w;
  assign wr_w = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_w = PSEL_I && PENABLE_I && !PWRITE_I;

  // control register: mode and loopback
  logic [31:0] ctrl_q;
  ela_mode_t mode_w;
  logic loop_w;
  // mode decode is combinational off the control register
  assign mode_w = ela_mode_t'(ctrl_q[`ELA_CTRL_MODE_LSB +: 2]);
  assign loop_w = ctrl_q[`ELA_CTRL_LOOP_BIT];

  // only mode and loopback bits are kept; the rest read back zero
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_q <= `ELA_CTRL_RST;
    end else if (wr_w && hit(PADDR_I, `ELA_CTRL_OFS)) begin
      ctrl_q <= {29'h0, PWDATA_I[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection and masking hierarchy
  logic framed_w;
  logic pcm30_w;
  assign framed_w = (mode_w != ELA_E1_UNFRAMED);
  assign pcm30_w = (mode_w == ELA_E1_PCM30);

  logic los_w;
  logic lof_w;
  logic ais_w;
  logic ssl_w;
  ela_alarm_t alarm_d;
  ela_alarm_t alarm_q;

  // masking is done before the level flags, so status sees only reported alarms
  assign los_w = !(sync_q[0] && sync_q[1]);
  assign lof_w = framed_w && !los_w && !sync_q[2];
  assign ais_w = sync_q[3] && !los_w && !lof_w;
  assign ssl_w = pcm30_w && !los_w && !sync_q[5];

  // no detector sees signalling content without a line signal
  always_comb begin
    alarm_d = '0;
    alarm_d[`ELA_B_LOS] = los_w;
    alarm_d[`ELA_B_LOF] = lof_w;
    alarm_d[`ELA_B_AIS] = ais_w;
    alarm_d[`ELA_B_RAI] = framed_w && !los_w && !lof_w && sync_q[4];
    alarm_d[`ELA_B_SSL] = ssl_w;
    alarm_d[`ELA_B_RMA] = pcm30_w && !los_w && !lof_w && sync_q[6];
    alarm_d[`ELA_B_SSA] = !los_w && !lof_w && sync_q[7];
  end

  // level flags follow the condition every cycle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // downstream insertion
  // ais goes out from reset on, since no upstream traffic is known yet
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TX_AIS_O <= 1'b1;
    end else begin
      TX_AIS_O <= !sync_q[8];
    end
  end

  // timeslot-16 ais only where full ais is not already covering it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TX_TS16_AIS_O <= 1'b0;
    end else begin
      TX_TS16_AIS_O <= pcm30_w && sync_q[8] && !sync_q[9];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  logic [CW-1:0] flash_cnt_q;
  logic flash_q;

  // counter idles at zero so each loopback starts with the lamp on
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (!loop_w) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q == CW'(FLASH_CYC - 1)) begin
      flash_cnt_q <= '0;
      flash_q <= !flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
    end
  end

  // alarm lamp: any reported alarm, in step with the alarm outputs
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ALARM_LED_O <= 1'b0;
    end else begin
      ALARM_LED_O <= |alarm_q;
    end
  end

  // activity lamp is lit on the first half period of each loopback
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACT_LED_O <= 1'b0;
    end else begin
      ACT_LED_O <= loop_w && !flash_q;
    end
  end

  // alarm levels out through a register of their own
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ALARM_O <= '0;
    end else begin
      ALARM_O <= alarm_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, mask, interrupt
  ela_alarm_t stat_q;
  ela_alarm_t mask_q;
  ela_alarm_t rise_w;
  ela_alarm_t prev_q;
  logic stat_rd_w;
  ela_alarm_t stat_d;

  // rising edge of the registered level: a held alarm sets status once
  assign rise_w = alarm_q & ~prev_q;
  assign stat_rd_w = rd_w && hit(PADDR_I, `ELA_STAT_OFS);

  // clear only the bits the read returned, so an alarm rising
  // between setup and access is kept for the next read
  always_comb begin
    stat_d = stat_q;
    if (stat_rd_w) begin
      stat_d = stat_q & ~PRDATA_O[6:0];
    end
    stat_d = stat_d | rise_w; // set wins over the clear
  end

  // read clears, but a rising alarm in the same cycle still lands
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prev_q <= '0;
      stat_q <= '0;
    end else begin
      prev_q <= alarm_q;
      stat_q <= stat_d;
    end
  end

  // mask bits beyond the alarm set are dropped
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mask_q <= `ELA_MASK_RST;
    end else if (wr_w && hit(PADDR_I, `ELA_MASK_OFS)) begin
      mask_q <= PWDATA_I[6:0];
    end
  end

  // interrupt tracks the next status value, so it drops with the read
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data, zero-wait answer
  logic [31:0] rdata_d;
  logic known_w;
  // unmapped offsets read zero and flag a slave error

  always_comb begin
    rdata_d = 32'h0;
    known_w = 1'b1;
    case (PADDR_I)
      `ELA_CTRL_OFS: rdata_d = ctrl_q;
      `ELA_LIVE_OFS: rdata_d = {25'h0, alarm_q};
      `ELA_STAT_OFS: rdata_d = {25'h0, stat_q};
      `ELA_MASK_OFS: rdata_d = {25'h0, mask_q};
      default: known_w = 1'b0;
    endcase
  end

  // registered outputs: answer presented during the access cycle
  // no wait states: the answer stands in the cycle after setup
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !known_w;
      PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rdata_d : 32'h0;
    end
  end

endmodule : ela_line_alarm

// ==== test/ela_line_model.sv ====
`timescale 1ns/1ps
// far-side line gear: a set fault bit spoils one indication
module ela_line_model (
  input wire logic [9:0] flt_i,
  output logic [9:0] raw_o
);
  // healthy: code, freq, frame word, ts16 valid, upstream ok; faults flip bits
  assign raw_o = flt_i ^ 10'h327;
endmodule : ela_line_model

// ==== test/ela_line_alarm_asserts.sv ====
`timescale 1ns/1ps
`include "ela_cfg.svh"
module ela_line_alarm_asserts
  import ela_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic LINE_CODE_OK_I,
  input wire logic LINE_FREQ_OK_I,
  input wire logic FAW_FOUND_I,
  input wire logic AIS_SEEN_I,
  input wire logic REMOTE_BIT_I,
  input wire logic TS16_AIS_SEEN_I,
  input wire logic UP_TRAFFIC_OK_I,
  input wire logic UP_TS16_OK_I,
  input wire logic TX_AIS_O,
  input wire logic TX_TS16_AIS_O,
  input wire logic ALARM_LED_O,
  input wire logic [6:0] ALARM_O
);
  // six steady cycles outlast the two-flop sync and output stages
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic ok;
  assign ok = LINE_CODE_OK_I && LINE_FREQ_OK_I && FAW_FOUND_I;
  // mode shadow from control writes, so mode-bound alarms are expected only where they apply
  logic framed_q;
  logic pcm30_q;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      framed_q <= 1'b0;
      pcm30_q <= 1'b0;
    end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `ELA_CTRL_OFS) begin
      framed_q <= ela_mode_t'(PWDATA_I[`ELA_CTRL_MODE_LSB +: 2]) != ELA_E1_UNFRAMED;
      pcm30_q <= ela_mode_t'(PWDATA_I[`ELA_CTRL_MODE_LSB +: 2]) == ELA_E1_PCM30;
    end
  end
  ////////////////////////////////////////
  // detection, masking, indicators and downstream insertion
  los_set_a: assert property (!LINE_CODE_OK_I [*6] |-> ALARM_O[0]) else $error("los missing");
  los_hides_a: assert property (ALARM_O[0] |-> ALARM_O[2:1] == 2'b00) else $error("los mask");
  lof_hides_a: assert property (ALARM_O[1] |-> !ALARM_O[2]) else $error("lof mask");
  ais_set_a: assert property ((ok && AIS_SEEN_I) [*6] |-> ALARM_O[2]) else $error("ais missing");
  ais_clear_a: assert property ((ok && !AIS_SEEN_I) [*6] |-> !ALARM_O[2]) else $error("ais stuck");
  remote_set_a: assert property ((framed_q && ok && REMOTE_BIT_I) [*6] |-> ALARM_O[3])
    else $error("rai missing");
  slot_ais_a: assert property ((ok && TS16_AIS_SEEN_I) [*6] |-> ALARM_O[6]) else $error("ts16 ais");
  led_any_a: assert property (ALARM_LED_O == |ALARM_O) else $error("alarm led");
  tx_ais_a: assert property (!UP_TRAFFIC_OK_I [*6] |-> TX_AIS_O) else $error("tx ais missing");
  slot_excl_a: assert property (TX_TS16_AIS_O |-> !TX_AIS_O) else $error("ts16 with ais");
  slot_tx_a: assert property ((pcm30_q && UP_TRAFFIC_OK_I && !UP_TS16_OK_I) [*5] |-> TX_TS16_AIS_O)
    else $error("ts16 ais missing");
endmodule : ela_line_alarm_asserts
bind ela_line_alarm ela_line_alarm_asserts u_chk (.*);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, prdy, perr, err, txa, txt, led, act, irq, q;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [6:0] alm;
  logic [9:0] flt = 0, raw;
  int n_fail = 0, n_compared = 0, k;
  // mode, fault word, alarms, tx ais, tx ts16 ais
  logic [20:0] rows [14] = '{{2'h3, 10'h000, 9'h000}, {2'h3, 10'h001, 9'h004}, {2'h3, 10'h00e, 9'h004},
    {2'h3, 10'h00c, 9'h008}, {2'h0, 10'h004, 9'h000}, {2'h2, 10'h008, 9'h010}, {2'h2, 10'h010, 9'h020},
    {2'h3, 10'h020, 9'h040}, {2'h1, 10'h020, 9'h000}, {2'h3, 10'h040, 9'h080}, {2'h1, 10'h080, 9'h100},
    {2'h3, 10'h100, 9'h002}, {2'h3, 10'h200, 9'h001}, {2'h1, 10'h200, 9'h000}};
  always #10 clk = ~clk;
  ela_line_model u_line (.flt_i(flt), .raw_o(raw));
  ela_line_alarm #(.FLASH_CYC(4)) u_dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .LINE_CODE_OK_I(raw[0]), .LINE_FREQ_OK_I(raw[1]), .FAW_FOUND_I(raw[2]), .AIS_SEEN_I(raw[3]),
    .REMOTE_BIT_I(raw[4]), .TS16_VALID_I(raw[5]), .TS16_MF_BIT6_I(raw[6]), .TS16_AIS_SEEN_I(raw[7]),
    .UP_TRAFFIC_OK_I(raw[8]), .UP_TS16_OK_I(raw[9]), .TX_AIS_O(txa), .TX_TS16_AIS_O(txt),
    .ALARM_LED_O(led), .ACT_LED_O(act), .ALARM_O(alm), .IRQ_O(irq));
  ////////////////////////////////////////
  // apb master: idle edge first, so back-to-back calls never clash
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // wait for pready however long; only the watchdog ends this wait
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  // watchdog: the run needs well under 1000 cycles
  initial begin
    #50us;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    chk({txa, alm}, 8'h80);
    rstn <= 1'b1;
    // table rows: mode via ctrl, fault word via the line model
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, {30'h0, rows[i][20:19]});
      flt <= rows[i][18:9];
      repeat (6) @(posedge clk);
      chk({led, alm, txa, txt}, {|rows[i][8:2], rows[i][8:0]});
    end
    // unmapped offset gives an error answer and zero data
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // status is sticky and read-cleared; mask gates the irq line
    flt <= 10'h000;
    repeat (6) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0);
    flt <= 10'h001;
    repeat (6) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h00c, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk);
    chk({irq, alm}, 8'h01);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1);
    // loopback flashes the activity led, release stops it
    apb(1'b1, 12'h000, 32'h7);
    k = 0;
    q = act;
    repeat (24) begin
      @(posedge clk);
      k += int'(act !== q);
      q = act;
    end
    chk(k, 6);
    apb(1'b1, 12'h000, 32'h3);
    repeat (4) @(posedge clk);
    k = 0;
    repeat (12) begin
      @(posedge clk);
      k += int'(act !== 1'b0);
    end
    chk(k, 0);
    // mid-run reset: outputs fall back at once, control reads zero after release
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({txa, txt, led, act, irq, alm}, 12'h800);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    conclude();
  end
endmodule : testbench
